// File: pkg/etg_pkg.sv
// types for the emulator target strobe gating block
`default_nettype none
package etg_pkg;
  typedef enum logic {mode_monitor, mode_emulate} etg_mode_t;
  typedef struct packed {
    logic gated_pstrobe;
    logic gated_rdwr;
    logic code_map_select;
    logic xdata_map_select;
  } etg_cfg_t;
  typedef struct packed {
    logic pstrobe_n;
    logic rd_n;
    logic wr_n;
  } etg_bus_t;
  typedef struct packed {
    logic code_byte_command;
    logic code_window_read;
    logic xdata_byte_command;
    logic xdata_read;
  } etg_mon_t;
endpackage : etg_pkg
`default_nettype wire

// File: pkg/etg_regs.svh
// constants for the emulator target strobe gating block
// Contract
// RL1 - non-gated strap, emulation: program strobe when access pin low or above boundary
// RL2 - non-gated strap, monitor: program strobe for code commands, code mapped target
// RL3 - gated strap, emulation: code mapped target and (access low or above boundary)
// RL4 - gated strap, monitor: code commands, mapped target, access low or above boundary
// RL5 - gated strobes held inactive when the cycle is not a target access
// RL6 - non-gated read/write strap, emulation: strobes pass straight from processor
// RL7 - non-gated read/write strap, monitor: data commands only when xdata mapped target
// RL8 - gated read/write strap: strobes follow xdata mapping in both modes
// RL9 - mode indication high in monitor, low in emulation
// RL10 - mode controller switches monitor and emulation
// RL11 - internal reset output low while processor sits in internal reset
// RL12 - fetch marker high on first opcode byte and first interrupt call frame
// RL13 - timers halt at breakpoint and resume with emulation
// RL14 - break on external data move: timers one count short
// RL15 - start with code in target: one extra count unless break on data move
// RL16 - watchdog enabled after reset when disable pin open, disabled when grounded
// RL17 - primary trace lane records the selected source
// RL18 - first sync input feeds trace and break logic, second trace only
// RL19 - strobe gating combinational, inactive high when not enabled
`ifndef ETG_REGS_SVH
`define ETG_REGS_SVH
`define ETG_SEL_PRIMARY 2'h0
`define ETG_SEL_ALT     2'h1
`define ETG_SEL_EXT     2'h2
`define ETG_ADJ_NONE    2'h0
`define ETG_ADJ_MINUS   2'h1
`define ETG_ADJ_PLUS    2'h2
`define ETG_STROBE_OFF  1'h1
`define ETG_LANE_RST    8'h00
`endif

// File: src/etg_top.sv
// strobe gating, mode control, timer hold and trace select for the pod
`include "etg_regs.svh"
`default_nettype none
module etg_top (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire etg_pkg::etg_cfg_t cfg,
  input  wire etg_pkg::etg_bus_t cpu_bus,
  input  wire etg_pkg::etg_mon_t mon_acc,
  input  wire logic              external_access_n,
  input  wire logic [15:0]       fetch_addr,
  input  wire logic [15:0]       mem_boundary,
  input  wire logic              go_req,
  input  wire logic              break_hit,
  input  wire logic              break_sync_en,
  input  wire logic              external_data_move,
  input  wire logic              cpu_internal_reset,
  input  wire logic              first_byte_fetch,
  input  wire logic              irq_first_frame,
  input  wire logic              watchdog_disable_pin,
  input  wire logic [1:0]        trace_sel,
  input  wire logic [7:0]        port_primary,
  input  wire logic [7:0]        port_alt,
  input  wire logic [7:0]        trace_ext,
  input  wire logic              sync_input_zero,
  input  wire logic              sync_input_one,
  output etg_pkg::etg_bus_t      tgt_bus,
  output logic                   monitor_state,
  output logic                   emulation_state,
  output logic                   internal_reset_out_n,
  output logic                   fetch_marker,
  output logic                   timer_run,
  output logic [1:0]             timer_adjust,
  output logic                   timer_adjust_valid,
  output logic                   watchdog_enable,
  output logic [7:0]             trace_lane,
  output logic [1:0]             trace_sync
);

  etg_pkg::etg_mode_t mode_q;
  logic               started_tgt_q;
  logic               wd_pend_q;
  logic               code_ext;
  logic               mon_code;
  logic               mon_xdata;
  logic               pen;
  logic               xen;
  logic               brk;
  logic [7:0]         lane_d;

  // address above boundary or internal store disabled means a target fetch
  function automatic logic code_is_external(
    input logic        ea_n,
    input logic [15:0] addr,
    input logic [15:0] bound
  );
    code_is_external = !ea_n || (addr > bound);
  endfunction : code_is_external

  // sync zero may join the break condition; sync one never does
  assign brk = break_hit || (break_sync_en && sync_input_zero); // [RL18]

  // mode controller
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_q <= etg_pkg::mode_monitor;
    end else begin
      case (mode_q)
        etg_pkg::mode_monitor: begin
          if (go_req) begin
            mode_q <= etg_pkg::mode_emulate; // [RL10]
          end
        end
        etg_pkg::mode_emulate: begin
          if (brk) begin
            mode_q <= etg_pkg::mode_monitor; // [RL10]
          end
        end
        default: begin
          mode_q <= etg_pkg::mode_monitor;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      monitor_state   <= 1'b1;
      emulation_state <= 1'b0;
    end else begin
      monitor_state   <= !(mode_q == etg_pkg::mode_emulate) ? !go_req : brk; // [RL9]
      emulation_state <= (mode_q == etg_pkg::mode_emulate) ? !brk : go_req;
    end
  end

  // strobe gating stays combinational: a register here would shift the
  // strobe a whole cycle against the address on the target bus
  always_comb begin
    code_ext  = code_is_external(external_access_n, fetch_addr, mem_boundary);
    mon_code  = mon_acc.code_byte_command || mon_acc.code_window_read;
    mon_xdata = mon_acc.xdata_byte_command || mon_acc.xdata_read;
    pen       = 1'b0;
    xen       = 1'b0;
    if (mode_q == etg_pkg::mode_emulate) begin
      if (cfg.gated_pstrobe) begin
        pen = cfg.code_map_select && code_ext; // [RL3] [RL5]
      end else begin
        pen = code_ext; // [RL1]
      end
      if (cfg.gated_rdwr) begin
        xen = cfg.xdata_map_select; // [RL8] [RL5]
      end else begin
        xen = 1'b1; // [RL6]
      end
    end else begin
      if (cfg.gated_pstrobe) begin
        pen = mon_code && cfg.code_map_select && code_ext; // [RL4] [RL5]
      end else begin
        pen = mon_code && cfg.code_map_select; // [RL2]
      end
      if (cfg.gated_rdwr) begin
        xen = mon_xdata && cfg.xdata_map_select; // [RL8]
      end else begin
        xen = mon_xdata && cfg.xdata_map_select; // [RL7]
      end
    end
    tgt_bus.pstrobe_n = pen ? cpu_bus.pstrobe_n : `ETG_STROBE_OFF; // [RL19]
    tgt_bus.rd_n      = xen ? cpu_bus.rd_n : `ETG_STROBE_OFF; // [RL19]
    tgt_bus.wr_n      = xen ? cpu_bus.wr_n : `ETG_STROBE_OFF; // [RL19]
  end

  // processor status lines
  always_ff @(posedge clk) begin
    if (reset) begin
      internal_reset_out_n <= 1'b0;
      fetch_marker         <= 1'b0;
    end else begin
      internal_reset_out_n <= !cpu_internal_reset; // [RL11]
      fetch_marker         <= first_byte_fetch || irq_first_frame; // [RL12]
    end
  end

  // timer hold and break count correction
  always_ff @(posedge clk) begin
    if (reset) begin
      timer_run          <= 1'b0;
      started_tgt_q      <= 1'b0;
      timer_adjust       <= `ETG_ADJ_NONE;
      timer_adjust_valid <= 1'b0;
    end else begin
      timer_adjust_valid <= 1'b0;
      if (mode_q == etg_pkg::mode_monitor && go_req) begin
        timer_run     <= 1'b1; // [RL13]
        started_tgt_q <= cfg.code_map_select;
      end else if (mode_q == etg_pkg::mode_emulate && brk) begin
        timer_run          <= 1'b0; // [RL13]
        timer_adjust_valid <= 1'b1;
        if (external_data_move) begin
          timer_adjust <= started_tgt_q ? `ETG_ADJ_NONE : `ETG_ADJ_MINUS; // [RL14] [RL15]
        end else begin
          timer_adjust <= started_tgt_q ? `ETG_ADJ_PLUS : `ETG_ADJ_NONE; // [RL15]
        end
      end
    end
  end

  // open pin reads high; level caught one cycle after reset release
  always_ff @(posedge clk) begin
    if (reset) begin
      watchdog_enable <= 1'b0;
      wd_pend_q       <= 1'b1;
    end else if (wd_pend_q) begin
      watchdog_enable <= watchdog_disable_pin; // [RL16]
      wd_pend_q       <= 1'b0;
    end
  end

  // trace lane source select, bit by bit like a strap row
  for (genvar i = 0; i < 8; i++) begin : g_lane
    always_comb begin
      case (trace_sel)
        `ETG_SEL_PRIMARY: lane_d[i] = port_primary[i];
        `ETG_SEL_ALT:     lane_d[i] = port_alt[i];
        `ETG_SEL_EXT:     lane_d[i] = trace_ext[i];
        default:          lane_d[i] = port_primary[i];
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      trace_lane <= `ETG_LANE_RST;
      trace_sync <= 2'h0;
    end else begin
      trace_lane <= lane_d; // [RL17]
      trace_sync <= {sync_input_one, sync_input_zero}; // [RL18]
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  pstrobe_ng_emu_a: assert property ( // [RL1]
    mode_q == etg_pkg::mode_emulate && !cfg.gated_pstrobe
    |-> tgt_bus.pstrobe_n == (code_ext ? cpu_bus.pstrobe_n : 1'b1))
    else $error("non-gated program strobe wrong in emulation");
  pstrobe_ng_mon_a: assert property ( // [RL2]
    mode_q == etg_pkg::mode_monitor && !cfg.gated_pstrobe && !cfg.code_map_select
    |-> tgt_bus.pstrobe_n)
    else $error("program strobe reached target with code mapped local");
  pstrobe_g_emu_a: assert property ( // [RL3]
    mode_q == etg_pkg::mode_emulate && cfg.gated_pstrobe && !cpu_bus.pstrobe_n
    |-> !tgt_bus.pstrobe_n == (cfg.code_map_select && code_ext))
    else $error("gated program strobe wrong in emulation");
  pstrobe_g_mon_a: assert property ( // [RL4]
    mode_q == etg_pkg::mode_monitor && cfg.gated_pstrobe && !mon_code
    |-> tgt_bus.pstrobe_n)
    else $error("gated program strobe active without code command");
  rdwr_ng_emu_a: assert property ( // [RL6]
    mode_q == etg_pkg::mode_emulate && !cfg.gated_rdwr
    |-> tgt_bus.rd_n == cpu_bus.rd_n && tgt_bus.wr_n == cpu_bus.wr_n)
    else $error("non-gated read/write not passed through");
  rdwr_ng_mon_a: assert property ( // [RL7]
    mode_q == etg_pkg::mode_monitor && !(mon_xdata && cfg.xdata_map_select)
    |-> tgt_bus.rd_n && tgt_bus.wr_n)
    else $error("monitor read/write strobe without target data command");
  rdwr_gated_a: assert property ( // [RL8]
    cfg.gated_rdwr && !cfg.xdata_map_select |-> tgt_bus.rd_n && tgt_bus.wr_n)
    else $error("gated read/write active with xdata mapped local");
  mode_ind_a: assert property ( // [RL9]
    ##1 monitor_state == (mode_q == etg_pkg::mode_monitor)
    && emulation_state == !monitor_state)
    else $error("mode indication disagrees with mode");
  go_break_a: assert property ( // [RL10]
    mode_q == etg_pkg::mode_monitor && go_req |=> mode_q == etg_pkg::mode_emulate && timer_run)
    else $error("start request did not enter emulation");
  reset_out_a: assert property ( // [RL11]
    cpu_internal_reset |=> !internal_reset_out_n)
    else $error("internal reset output not low");
  fetch_mark_a: assert property ( // [RL12]
    (first_byte_fetch || irq_first_frame) |=> fetch_marker)
    else $error("fetch marker missing");
  timer_halt_a: assert property ( // [RL13]
    mode_q == etg_pkg::mode_emulate && brk |=> !timer_run && timer_adjust_valid)
    else $error("timers not halted at break");
  adj_xmove_a: assert property ( // [RL14]
    mode_q == etg_pkg::mode_emulate && brk && external_data_move && !started_tgt_q
    |=> timer_adjust == `ETG_ADJ_MINUS)
    else $error("missing one count short on data move break");
  adj_target_a: assert property ( // [RL15]
    mode_q == etg_pkg::mode_emulate && brk && started_tgt_q && !external_data_move
    |=> timer_adjust == `ETG_ADJ_PLUS)
    else $error("missing extra count after start in target");
  start_map_a: assert property ( // [RL15]
    mode_q == etg_pkg::mode_monitor && go_req |=> started_tgt_q == $past(cfg.code_map_select))
    else $error("start mapping not remembered");
  wd_catch_a: assert property ( // [RL16]
    $fell(wd_pend_q) |-> watchdog_enable == $past(watchdog_disable_pin))
    else $error("watchdog enable not caught after reset");
  lane_sel_a: assert property ( // [RL17]
    trace_sel == `ETG_SEL_ALT |=> trace_lane == $past(port_alt))
    else $error("trace lane not taken from alternate port");
  sync_brk_a: assert property ( // [RL18]
    mode_q == etg_pkg::mode_emulate && break_sync_en && sync_input_zero
    |=> mode_q == etg_pkg::mode_monitor)
    else $error("sync zero did not break");

  // pass cases too: a gate stuck inactive would satisfy every blocking check
  pstrobe_gate_off_a: assert property ( // [RL5]
    cfg.gated_pstrobe && !cfg.code_map_select |-> tgt_bus.pstrobe_n)
    else $error("gated program strobe active with code mapped local");
  pstrobe_ng_pass_a: assert property ( // [RL2]
    mode_q == etg_pkg::mode_monitor && !cfg.gated_pstrobe && mon_code && cfg.code_map_select
    |-> tgt_bus.pstrobe_n == cpu_bus.pstrobe_n)
    else $error("non-gated monitor program strobe not passed");
  pstrobe_g_pass_a: assert property ( // [RL4]
    mode_q == etg_pkg::mode_monitor && cfg.gated_pstrobe && mon_code
    && cfg.code_map_select && code_ext
    |-> tgt_bus.pstrobe_n == cpu_bus.pstrobe_n)
    else $error("gated monitor program strobe not passed");

  // read and write strobes
  rdwr_mon_pass_a: assert property ( // [RL7]
    mode_q == etg_pkg::mode_monitor && mon_xdata && cfg.xdata_map_select
    |-> tgt_bus.rd_n == cpu_bus.rd_n && tgt_bus.wr_n == cpu_bus.wr_n)
    else $error("monitor data strobe not passed to target");
  rdwr_g_emu_a: assert property ( // [RL8]
    mode_q == etg_pkg::mode_emulate && cfg.gated_rdwr && cfg.xdata_map_select
    |-> tgt_bus.rd_n == cpu_bus.rd_n && tgt_bus.wr_n == cpu_bus.wr_n)
    else $error("gated data strobe not passed in emulation");
  strobe_idle_a: assert property ( // [RL19]
    cpu_bus.pstrobe_n && cpu_bus.rd_n && cpu_bus.wr_n
    |-> tgt_bus.pstrobe_n && tgt_bus.rd_n && tgt_bus.wr_n)
    else $error("target strobe active while processor idle");

  // mode and timers
  mode_stay_a: assert property ( // [RL10]
    mode_q == etg_pkg::mode_monitor && !go_req |=> mode_q == etg_pkg::mode_monitor)
    else $error("monitor left without start request");
  emu_stay_a: assert property ( // [RL10]
    mode_q == etg_pkg::mode_emulate && !brk |=> mode_q == etg_pkg::mode_emulate && timer_run)
    else $error("emulation left without break");
  timer_idle_a: assert property ( // [RL13]
    mode_q == etg_pkg::mode_monitor && !go_req |=> !timer_run)
    else $error("timers run in monitor");
  adj_pulse_a: assert property ( // [RL13]
    timer_adjust_valid |=> !timer_adjust_valid)
    else $error("adjust valid longer than one cycle");
  adj_none_a: assert property ( // [RL14]
    mode_q == etg_pkg::mode_emulate && brk && external_data_move && started_tgt_q
    |=> timer_adjust == `ETG_ADJ_NONE)
    else $error("data move break after target start not exact");

  // status and trace
  reset_out_hi_a: assert property ( // [RL11]
    !cpu_internal_reset |=> internal_reset_out_n)
    else $error("internal reset output low without reset");
  fetch_low_a: assert property ( // [RL12]
    !first_byte_fetch && !irq_first_frame |=> !fetch_marker)
    else $error("fetch marker without first byte or call");
  wd_hold_a: assert property ( // [RL16]
    !wd_pend_q |=> $stable(watchdog_enable))
    else $error("watchdog enable moved after capture");
  lane_pri_a: assert property ( // [RL17]
    trace_sel == `ETG_SEL_PRIMARY |=> trace_lane == $past(port_primary))
    else $error("trace lane not taken from primary port");
  lane_ext_a: assert property ( // [RL17]
    trace_sel == `ETG_SEL_EXT |=> trace_lane == $past(trace_ext))
    else $error("trace lane not taken from external row");
  sync_trace_a: assert property ( // [RL18]
    1'b1 |=> trace_sync == {$past(sync_input_one), $past(sync_input_zero)})
    else $error("sync inputs not traced");
  sync_one_a: assert property ( // [RL18]
    mode_q == etg_pkg::mode_emulate && sync_input_one && !sync_input_zero && !break_hit
    |=> mode_q == etg_pkg::mode_emulate)
    else $error("sync one stopped emulation");

  emu_run_c: cover property (go_req ##[1:20] brk);
  tgt_fetch_c: cover property (!tgt_bus.pstrobe_n && mode_q == etg_pkg::mode_emulate);
  mon_xread_c: cover property (!tgt_bus.rd_n && mode_q == etg_pkg::mode_monitor);
  adj_plus_c: cover property (timer_adjust_valid && timer_adjust == `ETG_ADJ_PLUS);
  sync_brk_c: cover property (mode_q == etg_pkg::mode_emulate && break_sync_en && sync_input_zero);

endmodule : etg_top
`default_nettype wire

// File: tb/etg_tgt_model.sv
// target side model: decodes which strobes reach the target memory
`default_nettype none
module etg_tgt_model (
  input  wire etg_pkg::etg_bus_t tgt_bus,
  output logic                   prog_sel,
  output logic                   xdat_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  // rd and wr share one chip decode on the target, so one select covers both
  assign prog_sel = !tgt_bus.pstrobe_n;
  assign xdat_sel = !(tgt_bus.rd_n && tgt_bus.wr_n);
endmodule : etg_tgt_model
`default_nettype wire

// File: tb/etg_top_test.sv
// self-checking bench for the strobe gating block
`default_nettype none
module etg_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, ext_n, go_req, break_hit, sync_en, data_move, cpu_rst, first_fetch, irq_frame;
  logic wd_pin, sync0, sync1, mon_st, emu_st, rst_out_n, fetch_mk, t_run, adj_v, wd_en;
  logic prog_sel, xdat_sel;
  logic [1:0]        trace_sel, t_adj, t_sync;
  logic [7:0]        p_pri, p_alt, t_ext, t_lane;
  logic [15:0]       addr, bound;
  etg_pkg::etg_cfg_t cfg;
  etg_pkg::etg_bus_t cpu_bus, tgt_bus;
  etg_pkg::etg_mon_t mon_acc;
  int                n_mismatch, n_checks, cycles;

  etg_top dut (.clk(clk), .reset(reset), .cfg(cfg), .cpu_bus(cpu_bus), .mon_acc(mon_acc),
    .external_access_n(ext_n), .fetch_addr(addr), .mem_boundary(bound), .go_req(go_req),
    .break_hit(break_hit), .break_sync_en(sync_en), .external_data_move(data_move),
    .cpu_internal_reset(cpu_rst), .first_byte_fetch(first_fetch), .irq_first_frame(irq_frame),
    .watchdog_disable_pin(wd_pin), .trace_sel(trace_sel), .port_primary(p_pri),
    .port_alt(p_alt), .trace_ext(t_ext), .sync_input_zero(sync0), .sync_input_one(sync1),
    .tgt_bus(tgt_bus), .monitor_state(mon_st), .emulation_state(emu_st),
    .internal_reset_out_n(rst_out_n), .fetch_marker(fetch_mk), .timer_run(t_run),
    .timer_adjust(t_adj), .timer_adjust_valid(adj_v), .watchdog_enable(wd_en),
    .trace_lane(t_lane), .trace_sync(t_sync));
  etg_tgt_model target (.tgt_bus(tgt_bus), .prog_sel(prog_sel), .xdat_sel(xdat_sel));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // expected strobes: bits gp, gr, code map, xdata map, access_n, above, command, kind
  // c is what the processor drives; a disabled strobe reads high
  function automatic logic [2:0] exp_bus(input logic emu, input logic [7:0] v,
                                         input logic [2:0] c);
    logic lo_hi, pen, xen;
    lo_hi = !v[4] | v[5];
    if (emu) begin
      pen = v[0] ? (v[2] & lo_hi) : lo_hi;
      xen = v[1] ? v[3] : 1'b1;
    end else begin
      pen = v[6] & v[2] & (v[0] ? lo_hi : 1'b1);
      xen = v[6] & v[3];
    end
    return {pen ? c[2] : 1'b1, xen ? c[1] : 1'b1, xen ? c[0] : 1'b1};
  endfunction : exp_bus

  task automatic do_reset(input int n);
    reset = 1'b1;
    repeat (n) @(negedge clk);
    chk("monitor_state", 8'h01, 8'(mon_st));
    chk("emulation_state", 8'h00, 8'(emu_st));
    reset = 1'b0;
    @(negedge clk);
    chk("watchdog_enable", 8'(wd_pin), 8'(wd_en));
    $display("test reset done");
  endtask : do_reset

  task automatic go_emulation_state(input logic cmap);
    cfg.code_map_select = cmap;
    go_req = 1'b1;
    @(negedge clk);
    go_req = 1'b0;
    chk("emulation_state", 8'h01, 8'(emu_st));
    chk("timer_run", 8'h01, 8'(t_run));
  endtask : go_emulation_state

  task automatic strobe_sweep(input logic emu);
    logic [7:0] v;
    logic [2:0] c, e;
    for (int i = 0; i < 256; i++) begin
      v = 8'(i);
      c = {v[7] ^ v[1], v[7] ^ v[4], v[5] ^ v[2]};
      @(negedge clk);
      cfg = {v[0], v[1], v[2], v[3]};
      cpu_bus = c;
      ext_n = v[4];
      bound = emu ? 16'h0fff : 16'h7fff;
      addr = v[5] ? 16'(bound + 16'h0001) : bound;
      mon_acc = v[6] ? (v[7] ? 4'ha : 4'h5) : 4'h0;
      #1;
      e = exp_bus(emu, v, c);
      chk("tgt_bus", 8'(e), 8'(tgt_bus));
      chk("prog_sel", 8'(!e[2]), 8'(prog_sel));
      chk("xdat_sel", 8'(!(e[1] && e[0])), 8'(xdat_sel));
    end
    mon_acc = 4'h0;
    $display("test strobes mode %0d done", emu);
  endtask : strobe_sweep

  // break with sync zero raised first while sync_en is low: it must not stop emulation unless enabled
  task automatic run_break(input logic cmap, input logic mv, input logic [1:0] adj,
                           input logic by_sync);
    @(negedge clk);
    go_emulation_state(cmap);
    sync0 = 1'b1;
    @(negedge clk);
    chk("monitor_state", 8'h00, 8'(mon_st));
    sync0 = by_sync;
    sync_en = by_sync;
    break_hit = !by_sync;
    data_move = mv;
    @(negedge clk);
    {sync0, sync_en, break_hit, data_move} = 4'h0;
    chk("monitor_state", 8'h01, 8'(mon_st));
    chk("timer_run", 8'h00, 8'(t_run));
    chk("timer_adjust_valid", 8'h01, 8'(adj_v));
    chk("timer_adjust", 8'(adj), 8'(t_adj));
    @(negedge clk);
    chk("timer_adjust_valid", 8'h00, 8'(adj_v));
    $display("test break map %0d move %0d done", cmap, mv);
  endtask : run_break

  initial begin
    logic [7:0] lanes [4];
    lanes = '{8'h5a, 8'ha5, 8'h3c, 8'h5a};
    {reset, wd_pin, cpu_bus, mon_acc, cfg} = {2'h3, 3'h0, 4'h0, 4'h0};
    {ext_n, go_req, break_hit, sync_en, data_move, cpu_rst} = 6'h20;
    {first_fetch, irq_frame, sync0, sync1, trace_sel, addr} = {6'h00, 16'h0000};
    bound = 16'h7fff;
    {p_pri, p_alt, t_ext} = {8'h5a, 8'ha5, 8'h3c};
    {n_mismatch, n_checks, cycles} = {32'd0, 32'd0, 32'd0};
    do_reset(16);
    strobe_sweep(1'b0);
    @(negedge clk);
    go_emulation_state(1'b0);
    strobe_sweep(1'b1);
    cfg = 4'h0;
    break_hit = 1'b1;
    @(negedge clk);
    break_hit = 1'b0;
    run_break(1'b1, 1'b0, 2'h2, 1'b0);
    run_break(1'b1, 1'b1, 2'h0, 1'b1);
    run_break(1'b0, 1'b1, 2'h1, 1'b0);
    run_break(1'b0, 1'b0, 2'h0, 1'b1);
    for (int s = 0; s < 4; s++) begin
      trace_sel = 2'(s);
      cpu_rst = (s == 0);
      first_fetch = (s == 1);
      irq_frame = (s == 2);
      sync1 = (s == 1);
      @(negedge clk);
      chk("trace_lane", lanes[s], t_lane);
      chk("internal_reset_out_n", 8'(s != 0), 8'(rst_out_n));
      chk("fetch_marker", 8'(s == 1 || s == 2), 8'(fetch_mk));
      chk("trace_sync", 8'(s == 1) << 1, 8'(t_sync));
    end
    $display("test status done");
    go_emulation_state(1'b0);
    wd_pin = 1'b0;
    do_reset(2);
    end_of_test();
  end
endmodule : etg_top_test
`default_nettype wire
